// ===== hdl/rxafc_map.svh
`ifndef RXAFC_MAP_SVH
`define RXAFC_MAP_SVH

// Register byte offsets on the APB window.
`define RXAFC_CFG_OFS        8'hAC
`define RXAFC_STAT_OFS       8'hB4

// Configuration register reset value and writable bits.
`define RXAFC_CFG_RST        32'h0000_0000
`define RXAFC_CFG_WMASK      32'h00FF_FFFF

// Configuration field positions.
`define RXAFC_HI_LSB         16
`define RXAFC_LO_LSB         8
`define RXAFC_DUR_LSB        4
`define RXAFC_MULT_BIT       3
`define RXAFC_BRD_BIT        2
`define RXAFC_ADD_BIT        1
`define RXAFC_ANY_BIT        0

// Status register field positions.
`define RXAFC_ST_STATE_LSB   0
`define RXAFC_ST_BP_BIT      2
`define RXAFC_ST_PREQ_BIT    3
`define RXAFC_ST_PZERO_BIT   4
`define RXAFC_ST_HI_BIT      5
`define RXAFC_ST_LO_BIT      6

// One threshold unit is 64 bytes of receive FIFO data.
`define RXAFC_LEVEL_SHIFT    6

// Timing: clock period, base duration step and the 10 Mb/s extension.
`define RXAFC_CLK_NS         50
`define RXAFC_UNIT_NS        5000
`define RXAFC_EXTRA10_NS     2200
`define RXAFC_UNIT_CYC       ((`RXAFC_UNIT_NS + `RXAFC_CLK_NS - 1) / `RXAFC_CLK_NS)
`define RXAFC_EXTRA10_CYC    ((`RXAFC_EXTRA10_NS + `RXAFC_CLK_NS - 1) / `RXAFC_CLK_NS)

// Codes from this one upward step by ten base units each.
`define RXAFC_LONG_CODE      4'h4
`define RXAFC_LONG_STEP      10

`endif

// ===== hdl/rxafc_pkg.sv
package rxafc_pkg;

    // Controller state, Gray coded along IDLE-JAM and IDLE-PAUSED.
    typedef enum logic [1:0] {
        RXAFC_IDLE   = 2'b00,
        RXAFC_JAM    = 2'b01,
        RXAFC_PAUSED = 2'b10
    } rxafc_state_e;

    // Low 24 bits of the configuration register.
    typedef struct packed {
        logic [7:0] hiLevel;
        logic [7:0] loLevel;
        logic [3:0] durCode;
        logic       onMulticast;
        logic       onBroadcast;
        logic       onOwnAddr;
        logic       onAnyFrame;
    } rxafc_cfg_s;

    // Receive frame events from the MAC, one-cycle pulses with flags.
    typedef struct packed {
        logic preamble;
        logic daValid;
        logic multicast;
        logic broadcast;
        logic ownAddr;
    } rxafc_frame_s;

endpackage

// ===== hdl/rxafc_top.sv
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rxafc_map.svh"

module rxafc_top #(
    parameter int P_UNIT_CYC    = `RXAFC_UNIT_CYC,
    parameter int P_EXTRA10_CYC = `RXAFC_EXTRA10_CYC
) (
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // APB slave.
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Receive side status from the MAC.
    input  wire logic [14:0]           rxFifoLevel,
    input  wire rxafc_pkg::rxafc_frame_s frameEvt,
    // Link and transmitter state.
    input  wire logic                  fullDuplex,
    input  wire logic                  linkSpeed100,
    input  wire logic                  txEnabled,
    // Flow control actions toward the MAC.
    output logic                       backPressure,
    output logic                       pauseReq,
    output logic                       pauseZeroTime,
    input  wire logic                  pauseAck
);

    // Registers and their next values.
    logic [31:0]             cfgReg_ff;
    logic [31:0]             prdata_ff;
    logic [31:0]             nxt_prdata;
    logic [15:0]             jamCnt_ff;
    logic [15:0]             nxt_jamCnt;
    logic                    bp_ff;
    logic                    pauseReq_ff;
    logic                    pauseZero_ff;
    rxafc_pkg::rxafc_state_e state_ff;
    rxafc_pkg::rxafc_state_e nxt_state;

    // Decoded configuration and level compares.
    rxafc_pkg::rxafc_cfg_s   cfg;
    logic [14:0]             hiBytes;
    logic [14:0]             loBytes;
    logic                    hiReached;
    logic                    belowLo;
    logic                    frameMatch;
    logic                    trigHalf;
    logic                    trigPause;
    logic                    trigZero;
    logic                    jamDone;
    logic [15:0]             jamLoad;

    // APB decode.
    logic                    setupPhase;
    logic                    accessPhase;
    logic                    hitCfg;
    logic                    hitStat;
    logic [31:0]             statWord;

    // The low 24 bits of the configuration register map onto the struct.
    assign cfg = rxafc_pkg::rxafc_cfg_s'(cfgReg_ff[23:0]);

    // Thresholds are held in 64-byte units, so shift them into bytes.
    assign hiBytes   = {1'b0, cfg.hiLevel, 6'h00};
    assign loBytes   = {1'b0, cfg.loLevel, 6'h00};
    assign hiReached = (rxFifoLevel >= hiBytes);
    assign belowLo   = (rxFifoLevel < loBytes);

    // Frame selection for half duplex. The any-frame bit takes the bare
    // preamble so the address decode is never waited for; this is what
    // lets the jam land before the frame has got very far.
    always_comb begin
        if (cfg.onAnyFrame) begin
            frameMatch = frameEvt.preamble;
        end else begin
            frameMatch = frameEvt.daValid &
                         ((cfg.onMulticast & frameEvt.multicast) |
                          (cfg.onBroadcast & frameEvt.broadcast) |
                          (cfg.onOwnAddr & frameEvt.ownAddr));
        end
    end

    // Half-duplex trigger: level reached, a matching frame, and a live
    // transmitter. Full duplex never reaches this path.
    assign trigHalf = !fullDuplex && txEnabled && hiReached && frameMatch;

    // Full-duplex triggers. A new pause is refused while the previous one
    // is still queued, so a level that stays high asks only once.
    assign trigPause = fullDuplex && cfg.onAnyFrame && txEnabled && hiReached && !pauseReq_ff;
    assign trigZero  = cfg.onAnyFrame && txEnabled && belowLo && !pauseReq_ff;

    // Duration in system clock cycles: base units from the code, scaled by
    // the unit count, plus the fixed extension when running at 10 Mb/s.
    function automatic logic [15:0] dur_cycles(input logic [3:0] code,
                                               input logic       fast);
        int units;
        int total;
        units = 0;
        unique case (code)
            4'h0: units = 1;
            4'h1: units = 2;
            4'h2: units = 3;
            4'h3: units = 5;
            default: units = `RXAFC_LONG_STEP * (int'(code) - int'(`RXAFC_LONG_CODE) + 1);
        endcase
        total = units * P_UNIT_CYC;
        if (!fast) begin
            total = total + P_EXTRA10_CYC;
        end
        return 16'(total);
    endfunction

    assign jamLoad = dur_cycles(cfg.durCode, linkSpeed100);

    // The jam ends on terminal count, and also at once when the transmitter
    // stops or the link turns full duplex, since back pressure has no
    // meaning there.
    assign jamDone = (jamCnt_ff == 16'h0001) || !txEnabled || fullDuplex;

    // Next state of the controller.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rxafc_pkg::RXAFC_IDLE: begin
                if (trigHalf) begin
                    nxt_state = rxafc_pkg::RXAFC_JAM;
                end else if (trigPause) begin
                    nxt_state = rxafc_pkg::RXAFC_PAUSED;
                end
            end
            rxafc_pkg::RXAFC_JAM: begin
                if (jamDone) begin
                    nxt_state = rxafc_pkg::RXAFC_IDLE;
                end
            end
            rxafc_pkg::RXAFC_PAUSED: begin
                // Leaving flow control or full duplex drops the wait.
                if (!cfg.onAnyFrame || !fullDuplex || trigZero) begin
                    nxt_state = rxafc_pkg::RXAFC_IDLE;
                end
            end
            default: begin
                nxt_state = rxafc_pkg::RXAFC_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= rxafc_pkg::RXAFC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Jam duration counter: loaded on entry, counts down while jamming.
    always_comb begin
        nxt_jamCnt = jamCnt_ff;
        if (state_ff == rxafc_pkg::RXAFC_IDLE && trigHalf) begin
            nxt_jamCnt = jamLoad;
        end else if (state_ff == rxafc_pkg::RXAFC_JAM) begin
            nxt_jamCnt = jamDone ? 16'h0000 : jamCnt_ff - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            jamCnt_ff <= 16'h0000;
        end else begin
            jamCnt_ff <= nxt_jamCnt;
        end
    end

    // Back pressure output is registered so it is glitch free on the MAC.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bp_ff <= 1'b0;
        end else begin
            bp_ff <= (nxt_state == rxafc_pkg::RXAFC_JAM);
        end
    end

    // Pause request: raised for a full or a zero pause, held until the MAC
    // takes it in its next transmit window.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pauseReq_ff  <= 1'b0;
            pauseZero_ff <= 1'b0;
        end else if (state_ff == rxafc_pkg::RXAFC_IDLE && !trigHalf && trigPause) begin
            pauseReq_ff  <= 1'b1;
            pauseZero_ff <= 1'b0;
        end else if (state_ff == rxafc_pkg::RXAFC_PAUSED && fullDuplex && trigZero) begin
            pauseReq_ff  <= 1'b1;
            pauseZero_ff <= 1'b1;
        end else if (pauseAck) begin
            pauseReq_ff  <= 1'b0;
        end
    end

    // A request queued while the transmitter is off is simply held back.
    assign pauseReq      = pauseReq_ff && txEnabled;
    assign pauseZeroTime = pauseZero_ff;
    assign backPressure  = bp_ff;

    // APB phases. The slave never waits, so every access completes in the
    // first access cycle.
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign hitCfg      = (paddr == `RXAFC_CFG_OFS);
    assign hitStat     = (paddr == `RXAFC_STAT_OFS);
    assign pready      = 1'b1;
    assign pslverr     = accessPhase && !hitCfg && !hitStat;

    // Configuration register. Only bits 23:0 hold state; the top byte is
    // reserved and reads zero. Writes to status are ignored.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfgReg_ff <= `RXAFC_CFG_RST;
        end else if (accessPhase && pwrite && hitCfg) begin
            cfgReg_ff <= pwdata & `RXAFC_CFG_WMASK;
        end
    end

    // Status word built from live state.
    always_comb begin
        statWord = 32'h0000_0000;
        statWord[`RXAFC_ST_STATE_LSB +: 2] = state_ff;
        statWord[`RXAFC_ST_BP_BIT]         = bp_ff;
        statWord[`RXAFC_ST_PREQ_BIT]       = pauseReq_ff;
        statWord[`RXAFC_ST_PZERO_BIT]      = pauseZero_ff;
        statWord[`RXAFC_ST_HI_BIT]         = hiReached;
        statWord[`RXAFC_ST_LO_BIT]         = belowLo;
    end

    // Read data is captured in the setup cycle so the bus sees a flip-flop
    // output; the snapshot is one cycle older than the access edge.
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setupPhase && !pwrite) begin
            if (hitCfg) begin
                nxt_prdata = cfgReg_ff;
            end else if (hitStat) begin
                nxt_prdata = statWord;
            end else begin
                nxt_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

endmodule

// ===== tb/rxafc_properties.sv
`timescale 1ns/1ps
`include "rxafc_map.svh"

// Ties the flow-control outputs to their causes at the block's ports.
module rxafc_properties #(
    parameter int P_UNIT_CYC    = 4,
    parameter int P_EXTRA10_CYC = 2
) (
    // Clock and reset.
    input wire logic                    sys_clk,
    input wire logic                    rst,
    // APB slave.
    input wire logic [7:0]              paddr,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pslverr,
    // Link and MAC side.
    input wire rxafc_pkg::rxafc_frame_s frameEvt,
    input wire logic                    fullDuplex,
    input wire logic                    txEnabled,
    input wire logic                    backPressure,
    input wire logic                    pauseReq,
    input wire logic                    pauseZeroTime,
    input wire logic                    pauseAck
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [9:0] bpCnt_ff;

    // Length of the running jam, judged at the cycle it ends.
    always_ff @(posedge sys_clk) begin
        bpCnt_ff <= (rst || !backPressure) ? 10'h000 : bpCnt_ff + 10'h001;
    end

    // A normal pause handed over to the MAC.
    sequence sNormalAck;
        pauseReq && !pauseZeroTime && pauseAck;
    endsequence

    AST_BP_STOP: assert property ((!txEnabled || fullDuplex) |=> !backPressure)
        else $error("jam seen outside half duplex with transmitter on");
    AST_BP_CAUSE: assert property ($rose(backPressure) |-> $past(frameEvt.preamble || frameEvt.daValid))
        else $error("jam began without a frame event");
    AST_BP_MIN: assert property ($fell(backPressure) && $past(txEnabled && !fullDuplex) |-> bpCnt_ff >= P_UNIT_CYC)
        else $error("jam shorter than the shortest code");
    AST_BP_MAX: assert property (backPressure |-> bpCnt_ff < P_UNIT_CYC * 120 + P_EXTRA10_CYC)
        else $error("jam longer than the longest code");
    AST_NO_TX: assert property (!txEnabled |-> !pauseReq)
        else $error("pause request with transmitter off");
    AST_PREQ_HOLD: assert property (pauseReq && !pauseAck |=> pauseReq || !txEnabled)
        else $error("pause request dropped before acknowledge");
    AST_ZERO_HOLD: assert property (pauseReq && !pauseAck |=> !pauseReq || $stable(pauseZeroTime))
        else $error("pause kind changed while pending");
    AST_ONE_PAUSE: assert property (sNormalAck |=> !pauseReq ##1 (!pauseReq || pauseZeroTime))
        else $error("second normal pause for one crossing");
    AST_PREQ_FD: assert property ($rose(pauseReq) |-> $past(fullDuplex))
        else $error("pause request raised in half duplex");
    AST_UNMAPPED: assert property (psel && penable |-> pslverr == (paddr != `RXAFC_CFG_OFS && paddr != `RXAFC_STAT_OFS))
        else $error("slave error does not match the address map");
endmodule

// ===== tb/rxafc_mac_model.sv
`timescale 1ns/1ps

// Stands in for the MAC and the remote station: frames on command, pause requests acknowledged soon or late.
module rxafc_mac_model (
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // Bench commands.
    input  wire logic                    sendFrame,
    input  wire logic [2:0]              kind,
    input  wire logic [3:0]              ackDly,
    // Block side.
    input  wire logic                    pauseReq,
    output logic                         pauseAck,
    output rxafc_pkg::rxafc_frame_s      frameEvt
);
    logic [2:0] seq_ff;
    logic [3:0] wait_ff;
    logic       noise_ff;

    // A preamble pulse, then the decoded address two cycles later.
    always_ff @(posedge sys_clk) begin
        seq_ff <= rst ? 3'h0 : {seq_ff[1:0], sendFrame};
        noise_ff <= rst ? 1'b0 : ~noise_ff;
    end

    // Flags mean nothing away from the decode pulse, so they toggle there to expose misuse.
    assign frameEvt = {seq_ff[0], seq_ff[2], seq_ff[2] ? kind : {3{noise_ff}}};

    // The pause goes out in the next free transmit window; ackDly sets how far away that is.
    always_ff @(posedge sys_clk) begin
        wait_ff <= (rst || !pauseReq || pauseAck) ? 4'h0 : wait_ff + 4'h1;
        pauseAck <= !rst && pauseReq && !pauseAck && wait_ff == ackDly;
    end
endmodule

// ===== tb/rxafc_bench.sv
`timescale 1ns/1ps
`include "rxafc_map.svh"

module rxafc_bench;
    localparam int UNIT = 4;
    localparam int EXTRA = 2;
    logic                    sys_clk, rst, psel, penable, pwrite, pready, pslverr, errSeen, extra;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rdata;
    logic [14:0]             rxFifoLevel;
    logic                    fullDuplex, linkSpeed100, txEnabled, backPressure, pauseReq, pauseZeroTime, pauseAck;
    logic                    sendFrame;
    logic [2:0]              kind;
    logic [3:0]              ackDly;
    rxafc_pkg::rxafc_frame_s frameEvt;
    int                      n_errors = 0, total_checks = 0, cycles = 0, len, st;

    rxafc_top #(.P_UNIT_CYC(UNIT), .P_EXTRA10_CYC(EXTRA)) rxafc_top_i (
        .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .rxFifoLevel, .frameEvt, .fullDuplex, .linkSpeed100, .txEnabled,
        .backPressure, .pauseReq, .pauseZeroTime, .pauseAck);
    rxafc_mac_model rxafc_mac_model_i (.sys_clk, .rst, .sendFrame, .kind, .ackDly, .pauseReq, .pauseAck, .frameEvt);

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Cuts a hang short; the whole run needs about a fifth of this.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the idle cycle after it keeps each strobe to one assignment per edge.
    // The wait for pready has no limit of its own, so a hung slave is caught by the bench timeout.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic cfg(input logic [7:0] hi, input logic [7:0] lo, input logic [3:0] dur, input logic [3:0] trg);
        apb(1'b1, `RXAFC_CFG_OFS, {8'h00, hi, lo, dur, trg});
    endtask

    // Sends one frame; st is the sample where a jam first shows, len how many samples it lasts.
    task automatic frame(input logic [2:0] k);
        sendFrame <= 1'b1;
        kind <= k;
        @(posedge sys_clk);
        sendFrame <= 1'b0;
        len = 0;
        st = 0;
        while (backPressure !== 1'b1 && st < 8) begin
            @(posedge sys_clk);
            st++;
        end
        while (backPressure === 1'b1 && len < 600) begin
            @(posedge sys_clk);
            len++;
        end
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic quiet;
        extra = 1'b0;
        repeat (20) begin
            @(posedge sys_clk);
            extra |= pauseReq;
        end
    endtask

    // Waits for a pause request, checks its kind, then that no further one follows.
    task automatic pause_seen(input logic z);
        int w;
        w = 0;
        while (pauseReq !== 1'b1 && w < 40) begin
            @(posedge sys_clk);
            w++;
        end
        check(pauseReq, 1);
        check(pauseZeroTime, z);
        while (pauseReq === 1'b1 && w < 80) begin
            @(posedge sys_clk);
            w++;
        end
        quiet();
        check(extra, 0);
    endtask

    function automatic int bp_len(input logic [3:0] c, input logic fast);
        int u;
        u = (c < 4) ? ((c == 3) ? 5 : c + 1) : 10 * (c - 3);
        return u * UNIT + (fast ? 0 : EXTRA);
    endfunction

    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence: registers, jam lengths, trigger selection, then full-duplex pauses.
    initial begin
        logic [3:0] t;
        logic [2:0] k;
        rst = 1'b1;
        {psel, penable, pwrite, sendFrame, fullDuplex, linkSpeed100} = 6'h00;
        {paddr, pwdata, rxFifoLevel, kind, ackDly} = '0;
        txEnabled = 1'b1;
        void'($urandom(32'hb711d927));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, `RXAFC_CFG_OFS, 32'h0);
        check(rdata, `RXAFC_CFG_RST);
        apb(1'b1, `RXAFC_CFG_OFS, 32'hFFFF_FFFF);
        apb(1'b0, `RXAFC_CFG_OFS, 32'h0);
        check(rdata, `RXAFC_CFG_WMASK);
        apb(1'b0, 8'h10, 32'h0);
        check(rdata, 0);
        check(errSeen, 1);
        rxFifoLevel <= 15'h0C8;
        for (int s = 0; s < 2; s++) begin
            linkSpeed100 <= s[0];
            for (int c = 0; c < 16; c++) begin
                cfg(8'h03, 8'h01, c[3:0], {3'($urandom), 1'b1});
                frame(3'($urandom));
                check(len, bp_len(c[3:0], s[0]));
                check(st, 2);
            end
        end
        cfg(8'h03, 8'h01, 4'h0, 4'h1);
        rxFifoLevel <= 15'h0BF;
        frame(3'h7);
        check(len, 0);
        rxFifoLevel <= 15'h0C0;
        frame(3'h0);
        check(len, bp_len(4'h0, 1'b1));
        txEnabled <= 1'b0;
        frame(3'h7);
        check(len, 0);
        txEnabled <= 1'b1;
        repeat (24) begin
            t = 4'($urandom) & 4'hE;
            k = 3'($urandom);
            cfg(8'h03, 8'h01, 4'h0, t);
            frame(k);
            check(len, (|(t[3:1] & k)) ? bp_len(4'h0, 1'b1) : 0);
        end
        fullDuplex <= 1'b1;
        cfg(8'h03, 8'h02, 4'hF, 4'hF);
        repeat (2) begin
            ackDly <= 4'($urandom);
            txEnabled <= 1'b0;
            rxFifoLevel <= 15'h0C0;
            quiet();
            check(extra, 0);
            txEnabled <= 1'b1;
            pause_seen(1'b0);
            apb(1'b0, `RXAFC_STAT_OFS, 32'h0);
            check(rdata, (32'(rxafc_pkg::RXAFC_PAUSED) << `RXAFC_ST_STATE_LSB) | (32'h1 << `RXAFC_ST_HI_BIT));
            frame(3'h7);
            check(len, 0);
            rxFifoLevel <= 15'h07F;
            pause_seen(1'b1);
        end
        // Without the any-frame bit, full duplex must stay silent even with every other trigger set.
        cfg(8'h03, 8'h02, 4'hF, 4'hE);
        rxFifoLevel <= 15'h0C0;
        quiet();
        check(extra, 0);
        final_report();
    end
endmodule

bind rxafc_top rxafc_properties #(.P_UNIT_CYC(P_UNIT_CYC), .P_EXTRA10_CYC(P_EXTRA10_CYC)) rxafc_properties_i (
    .sys_clk, .rst, .paddr, .psel, .penable, .pslverr, .frameEvt, .fullDuplex, .txEnabled,
    .backPressure, .pauseReq, .pauseZeroTime, .pauseAck);
